// File: verilog/endpoint_fifo_irq_regs_defines.svh
`ifndef ENDPOINT_FIFO_IRQ_REGS_DEFINES_SVH
`define ENDPOINT_FIFO_IRQ_REGS_DEFINES_SVH

`define OFS_ISO_IN_PPF_EP8 16'he643
`define OFS_FORCE_IN_PKT_END 16'he648
`define OFS_FORCE_OUT_PKT_END 16'he649
`define OFS_EP2_FIFO_IE 16'he650
`define OFS_EP2_FIFO_IRQ 16'he651
`define OFS_EP4_FIFO_IE 16'he652
`define OFS_EP4_FIFO_IRQ 16'he653
`define OFS_EP6_FIFO_IE 16'he654
`define OFS_EP6_FIFO_IRQ 16'he655
`define OFS_EP8_FIFO_IE 16'he656
`define OFS_EP8_FIFO_IRQ 16'he657
`define OFS_IBN_IE 16'he658
`define OFS_IBN_IRQ 16'he659
`define OFS_NAK_IE 16'he65a
`define OFS_NAK_IRQ 16'he65b
`define OFS_USB_IE 16'he65c
`define OFS_TC_BYTE2 16'he6cf
`define OFS_TC_BYTE1 16'he6d0
`define OFS_TC_BYTE0 16'he6d1
`define OFS_EP2_FLAG_SEL 16'he6d2
`define OFS_EP2_STOP_ON_FLAG 16'he6d3
`define OFS_EP2_TRIGGER 16'he6d4

`define RST_PPF 2'h1
`define RST_TC 24'h000001
`define POS_AUTO_ADJUST 7
`define POS_SKIP 7
`define POS_EDGE_SELECT 3
`define POS_PROG_FLAG 2
`define POS_EMPTY_FLAG 1
`define POS_FULL_FLAG 0
`define POS_NAK_IBN 0
`define MASK_IBN 8'h3f
`define MASK_NAK 8'hfd
`define MASK_USB 8'h7f

`endif

// File: verilog/endpoint_fifo_irq_regs_pkg.sv
package endpoint_fifo_irq_regs_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic strobe;
		logic skip;
		logic [3:0] endpoint;
	} pkt_end_cmd_t;

	typedef struct packed {
		logic edge_select;
		logic prog;
		logic empty;
		logic full;
	} fifo_ie_t;

	typedef struct packed {
		logic prog;
		logic empty;
		logic full;
	} fifo_flags_t;
endpackage

// File: verilog/endpoint_fifo_irq_regs.sv
`include "endpoint_fifo_irq_regs_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module endpoint_fifo_irq_regs
	import endpoint_fifo_irq_regs_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Hardware events, one-cycle pulses from core logic
	input wire logic [11:0] fifo_flag_event_in,
	input wire logic [5:0] in_bulk_nak_event_in,
	input wire logic [5:0] nak_event_in,
	// Waveform engine status
	input wire logic ep2_prog_flag_in,
	input wire logic waveform_busy_in,
	// Control to the endpoint and waveform logic
	output logic [1:0] packets_per_frame_count_out,
	output logic auto_adjust_flag_out,
	output pkt_end_cmd_t force_in_cmd_out,
	output pkt_end_cmd_t force_out_cmd_out,
	output logic [6:0] usb_event_irq_enable_out,
	output logic [23:0] transaction_count_out,
	output logic [1:0] flag_select_out,
	output logic waveform_start_out,
	output logic waveform_stop_out,
	// Interrupt
	output logic irq_out
);

	logic rst_sync1;
	logic rst_n;
	reg_req_t req;
	logic [1:0] ppf;
	logic auto_adjust_flag;
	fifo_ie_t fifo_ie [4];
	fifo_flags_t fifo_irq [4];
	logic [5:0] ibn_ie;
	logic [5:0] ibn_irq;
	logic [6:0] nak_ie;
	logic [6:0] nak_irq;
	logic [6:0] usb_ie;
	logic [23:0] tc;
	logic [1:0] fsel;
	logic stop_en;
	logic prog_q;
	logic [7:0] next_rdata;
	logic next_irq;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	// Reset release passes two flops so all flops leave reset together
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_n <= rst_sync1;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			ppf <= `RST_PPF;
			auto_adjust_flag <= 1'b0;
		end else if (req.wr && hit(req.addr, `OFS_ISO_IN_PPF_EP8)) begin
			ppf <= req.wdata[1:0];
			auto_adjust_flag <= req.wdata[`POS_AUTO_ADJUST];
		end
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			force_in_cmd_out <= '0;
			force_out_cmd_out <= '0;
		end else begin
			force_in_cmd_out <= '{strobe: req.wr && hit(req.addr, `OFS_FORCE_IN_PKT_END),
				skip: req.wdata[`POS_SKIP], endpoint: req.wdata[3:0]};
			force_out_cmd_out <= '{strobe: req.wr && hit(req.addr, `OFS_FORCE_OUT_PKT_END),
				skip: req.wdata[`POS_SKIP], endpoint: req.wdata[3:0]};
		end
	end

	// FIFO flag enable and request pairs at base plus 2*i
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				fifo_ie[i] <= '0;
				fifo_irq[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (req.wr && hit(req.addr, `OFS_EP2_FIFO_IE + 16'(2 * i)))
					fifo_ie[i] <= req.wdata[3:0];
				// Set wins over a simultaneous clear so no event is lost
				if (req.wr && hit(req.addr, `OFS_EP2_FIFO_IRQ + 16'(2 * i)))
					fifo_irq[i] <= (fifo_irq[i] & ~req.wdata[2:0])
						| fifo_flag_event_in[3*i +: 3];
				else
					fifo_irq[i] <= fifo_irq[i] | fifo_flag_event_in[3*i +: 3];
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			ibn_ie <= '0;
			ibn_irq <= '0;
		end else begin
			if (req.wr && hit(req.addr, `OFS_IBN_IE))
				ibn_ie <= req.wdata[5:0];
			if (req.wr && hit(req.addr, `OFS_IBN_IRQ))
				ibn_irq <= (ibn_irq & ~req.wdata[5:0]) | in_bulk_nak_event_in;
			else
				ibn_irq <= ibn_irq | in_bulk_nak_event_in;
		end
	end

	// NAK bit 0 is the summary of pending in-bulk-nak requests that ibn_ie enables
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			nak_ie <= '0;
			nak_irq <= '0;
			usb_ie <= '0;
		end else begin
			if (req.wr && hit(req.addr, `OFS_NAK_IE))
				nak_ie <= {req.wdata[7:2], req.wdata[`POS_NAK_IBN]};
			if (req.wr && hit(req.addr, `OFS_USB_IE))
				usb_ie <= req.wdata[6:0];
			nak_irq[0] <= |(ibn_irq & ibn_ie);
			if (req.wr && hit(req.addr, `OFS_NAK_IRQ))
				nak_irq[6:1] <= (nak_irq[6:1] & ~req.wdata[7:2]) | nak_event_in;
			else
				nak_irq[6:1] <= nak_irq[6:1] | nak_event_in;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			tc <= `RST_TC;
			fsel <= '0;
			stop_en <= 1'b0;
		end else if (req.wr) begin
			if (hit(req.addr, `OFS_TC_BYTE2))
				tc[23:16] <= req.wdata;
			if (hit(req.addr, `OFS_TC_BYTE1))
				tc[15:8] <= req.wdata;
			if (hit(req.addr, `OFS_TC_BYTE0))
				tc[7:0] <= req.wdata;
			if (hit(req.addr, `OFS_EP2_FLAG_SEL))
				fsel <= req.wdata[1:0];
			if (hit(req.addr, `OFS_EP2_STOP_ON_FLAG))
				stop_en <= req.wdata[0];
		end
	end

	// Stop only on a rising programmable flag while a transaction runs
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			prog_q <= 1'b0;
			waveform_start_out <= 1'b0;
			waveform_stop_out <= 1'b0;
		end else begin
			prog_q <= ep2_prog_flag_in;
			waveform_start_out <= req.wr && hit(req.addr, `OFS_EP2_TRIGGER);
			waveform_stop_out <= stop_en && waveform_busy_in
				&& ep2_prog_flag_in && !prog_q;
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				`OFS_ISO_IN_PPF_EP8: next_rdata = {auto_adjust_flag, 5'h00, ppf};
				`OFS_EP2_FIFO_IE: next_rdata = {4'h0, fifo_ie[0]};
				`OFS_EP2_FIFO_IRQ: next_rdata = {5'h00, fifo_irq[0]};
				`OFS_EP4_FIFO_IE: next_rdata = {4'h0, fifo_ie[1]};
				`OFS_EP4_FIFO_IRQ: next_rdata = {5'h00, fifo_irq[1]};
				`OFS_EP6_FIFO_IE: next_rdata = {4'h0, fifo_ie[2]};
				`OFS_EP6_FIFO_IRQ: next_rdata = {5'h00, fifo_irq[2]};
				`OFS_EP8_FIFO_IE: next_rdata = {4'h0, fifo_ie[3]};
				`OFS_EP8_FIFO_IRQ: next_rdata = {5'h00, fifo_irq[3]};
				`OFS_IBN_IE: next_rdata = {2'h0, ibn_ie};
				`OFS_IBN_IRQ: next_rdata = {2'h0, ibn_irq};
				`OFS_NAK_IE: next_rdata = {nak_ie[6:1], 1'b0, nak_ie[0]};
				`OFS_NAK_IRQ: next_rdata = {nak_irq[6:1], 1'b0, nak_irq[0]};
				`OFS_USB_IE: next_rdata = {1'b0, usb_ie};
				`OFS_TC_BYTE2: next_rdata = tc[23:16];
				`OFS_TC_BYTE1: next_rdata = tc[15:8];
				`OFS_TC_BYTE0: next_rdata = tc[7:0];
				`OFS_EP2_FLAG_SEL: next_rdata = {6'h00, fsel};
				`OFS_EP2_STOP_ON_FLAG: next_rdata = {7'h00, stop_en};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Edge-select qualifies nothing here; the flag source decides edge vs level
	always_comb begin
		next_irq = 1'b0;
		for (int i = 0; i < 4; i++)
			next_irq = next_irq | (|(fifo_irq[i] & {fifo_ie[i].prog, fifo_ie[i].empty,
				fifo_ie[i].full}));
		next_irq = next_irq | (|(nak_irq & nak_ie));
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= 8'h00;
			irq_out <= 1'b0;
			packets_per_frame_count_out <= `RST_PPF;
			auto_adjust_flag_out <= 1'b0;
			usb_event_irq_enable_out <= '0;
			transaction_count_out <= `RST_TC;
			flag_select_out <= '0;
		end else begin
			rdata_out <= next_rdata;
			irq_out <= next_irq;
			packets_per_frame_count_out <= ppf;
			auto_adjust_flag_out <= auto_adjust_flag;
			usb_event_irq_enable_out <= usb_ie;
			transaction_count_out <= tc;
			flag_select_out <= fsel;
		end
	end

endmodule
`default_nettype wire

// File: sim/endpoint_fifo_irq_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module endpoint_fifo_irq_regs_props
	import endpoint_fifo_irq_regs_pkg::*;
(
	// Watched ports
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire pkt_end_cmd_t force_in_cmd_out,
	input wire pkt_end_cmd_t force_out_cmd_out,
	input wire logic [23:0] transaction_count_out,
	input wire logic [1:0] flag_select_out,
	input wire logic waveform_start_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	wire logic trig = wr_in && addr_in == 16'he6d4;
	a_trig_starts: assert property (trig |=> waveform_start_out)
		else $error("start missing");
	a_start_cause: assert property (waveform_start_out |-> $past(trig))
		else $error("start without write");
	a_in_end: assert property (wr_in && addr_in == 16'he648 |=>
		force_in_cmd_out == {1'b1, $past(wdata_in[7]), $past(wdata_in[3:0])})
		else $error("in packet end wrong");
	a_out_end: assert property (wr_in && addr_in == 16'he649 |=>
		force_out_cmd_out == {1'b1, $past(wdata_in[7]), $past(wdata_in[3:0])})
		else $error("out packet end wrong");
	a_wo_reads: assert property (rd_in && (addr_in == 16'he648 || addr_in == 16'he6d4)
		|=> rdata_out == 8'h00) else $error("write-only read not zero");
	a_irq_upper: assert property (rd_in && addr_in == 16'he651 |=> rdata_out[7:3] == 5'h00)
		else $error("request upper bits set");
	a_fsel_read: assert property (rd_in && addr_in == 16'he6d2 |=> rdata_out[7:2] == 6'h00)
		else $error("flag select upper bits set");
	a_tc_low: assert property (wr_in && addr_in == 16'he6d1 |->
		##2 transaction_count_out[7:0] == $past(wdata_in, 2)) else $error("count low byte");
	a_tc_high: assert property (wr_in && addr_in == 16'he6cf |->
		##2 transaction_count_out[23:16] == $past(wdata_in, 2)) else $error("count high byte");
	a_fsel_out: assert property (wr_in && addr_in == 16'he6d2 |->
		##2 flag_select_out == $past(wdata_in[1:0], 2)) else $error("flag select out");
	c_trig: cover property (trig ##1 waveform_start_out);
	c_in_end: cover property (force_in_cmd_out.strobe);
	c_tc: cover property (wr_in && addr_in == 16'he6d1);
endmodule
bind endpoint_fifo_irq_regs endpoint_fifo_irq_regs_props props_inst(.clock_in, .arst_n_in,
	.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .force_in_cmd_out, .force_out_cmd_out,
	.transaction_count_out, .flag_select_out, .waveform_start_out);
`default_nettype wire

// File: sim/endpoint_fifo_irq_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module endpoint_fifo_irq_regs_tb
	import endpoint_fifo_irq_regs_pkg::*;
;
	logic clock_in = 0, arst_n_in = 0, wr_in = 0, rd_in = 0;
	logic ep2_prog_flag_in = 0, waveform_busy_in = 0;
	logic [15:0] addr_in = 0;
	logic [7:0] wdata_in = 0, rdata_out, d;
	logic [11:0] fifo_flag_event_in = 0, ev;
	logic [5:0] in_bulk_nak_event_in = 0, nak_event_in = 0;
	logic [1:0] packets_per_frame_count_out, flag_select_out;
	logic auto_adjust_flag_out, waveform_start_out, waveform_stop_out, irq_out;
	pkt_end_cmd_t force_in_cmd_out, force_out_cmd_out;
	logic [6:0] usb_event_irq_enable_out;
	logic [23:0] transaction_count_out;
	logic [7:0] wv[13];
	int miscompares = 0, checked = 0;
	// Reset defaults, undefined request registers left out
	logic [15:0] rst_a[17] = '{16'he643, 16'he650, 16'he651, 16'he652, 16'he653, 16'he654,
		16'he655, 16'he656, 16'he657, 16'he658, 16'he65a, 16'he65c, 16'he6cf, 16'he6d0,
		16'he6d1, 16'he6d2, 16'he6d3};
	logic [15:0] rw_a[13] = '{16'he643, 16'he650, 16'he652, 16'he654, 16'he656, 16'he658,
		16'he65a, 16'he65c, 16'he6cf, 16'he6d0, 16'he6d1, 16'he6d2, 16'he6d3};
	endpoint_fifo_irq_regs endpoint_fifo_irq_regs_inst(.clock_in, .arst_n_in, .addr_in,
		.wdata_in, .wr_in, .rd_in, .rdata_out, .fifo_flag_event_in, .in_bulk_nak_event_in,
		.nak_event_in, .ep2_prog_flag_in, .waveform_busy_in, .packets_per_frame_count_out,
		.auto_adjust_flag_out, .force_in_cmd_out, .force_out_cmd_out,
		.usb_event_irq_enable_out, .transaction_count_out, .flag_select_out,
		.waveform_start_out, .waveform_stop_out, .irq_out);
	initial forever #25 clock_in = ~clock_in;
	function automatic logic [7:0] msk(input logic [15:0] a);
		case (a)
			16'he643: return 8'h83;
			16'he658: return 8'h3f;
			16'he65a: return 8'hfd;
			16'he65c: return 8'h7f;
			16'he6cf, 16'he6d0, 16'he6d1: return 8'hff;
			16'he6d2: return 8'h03;
			16'he6d3: return 8'h01;
			default: return 8'h0f;
		endcase
	endfunction
	task automatic chk(input string n, input logic [23:0] e, g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Strobes drop at the answering edge, so calls never collide
	task automatic wreg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1;
		@(posedge clock_in);
		wr_in <= 0;
		#1;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1;
		@(posedge clock_in);
		rd_in <= 0;
		#1 chk($sformatf("reg %h", a), e, rdata_out);
	endtask
	// Fixed window: a late stop pulse is as wrong as a missing one
	task automatic stop_win(input logic e);
		logic s;
		s = 0;
		repeat (5) begin
			@(posedge clock_in);
			#1 s |= waveform_stop_out;
		end
		chk("stop", e, s);
	endtask
	initial begin
		void'($urandom(32'h50c3));
		repeat (8) @(posedge clock_in);
		arst_n_in <= 1;
		repeat (3) @(posedge clock_in);
		chk("ppf", 1, packets_per_frame_count_out);
		chk("count", 1, transaction_count_out);
		foreach (rst_a[i]) rchk(rst_a[i], rst_a[i] == 16'he643 || rst_a[i] == 16'he6d1);
		$display("reset values done");
		foreach (rw_a[i]) begin
			wv[i] = $urandom;
			wreg(rw_a[i], wv[i]);
		end
		foreach (rw_a[i]) rchk(rw_a[i], wv[i] & msk(rw_a[i]));
		chk("ppf", wv[0][1:0], packets_per_frame_count_out);
		chk("adjust", wv[0][7], auto_adjust_flag_out);
		chk("usb ie", wv[7][6:0], usb_event_irq_enable_out);
		chk("count", {wv[8], wv[9], wv[10]}, transaction_count_out);
		chk("fsel", wv[11][1:0], flag_select_out);
		rchk(16'he644, 8'h00);
		$display("read write done");
		for (int i = 0; i < 4; i++) wreg(16'he650 + 16'(2 * i), 8'h00);
		wreg(16'he651, 8'hff);
		rchk(16'he651, 8'h00);
		ev = $urandom;
		ev[0] = 1;
		@(posedge clock_in) fifo_flag_event_in <= ev;
		@(posedge clock_in) fifo_flag_event_in <= 0;
		for (int i = 0; i < 4; i++) rchk(16'he651 + 16'(2 * i), {5'h0, ev[3 * i +: 3]});
		chk("irq masked", 0, irq_out);
		wreg(16'he650, 8'h07);
		repeat (2) @(posedge clock_in);
		#1 chk("irq", 1, irq_out);
		d = $urandom;
		wreg(16'he651, d);
		rchk(16'he651, {5'h0, ev[2:0] & ~d[2:0]});
		for (int i = 0; i < 4; i++) wreg(16'he651 + 16'(2 * i), 8'hff);
		repeat (2) @(posedge clock_in);
		#1 chk("irq clear", 0, irq_out);
		$display("requests done");
		// In-bulk-nak and nak requests, with the summary bit behind the in-bulk-nak enable
		ev = $urandom;
		ev[0] = 1;
		@(posedge clock_in) begin
			in_bulk_nak_event_in <= ev[5:0];
			nak_event_in <= ev[11:6];
		end
		@(posedge clock_in) begin
			in_bulk_nak_event_in <= 0;
			nak_event_in <= 0;
		end
		d = {ev[11:6], 1'b0, |(ev[5:0] & wv[5][5:0])};
		rchk(16'he659, {2'h0, ev[5:0]});
		rchk(16'he65b, d);
		chk("nak irq", |(d & wv[6] & 8'hfd), irq_out);
		wreg(16'he659, 8'hff);
		wreg(16'he65b, 8'hff);
		rchk(16'he65b, 8'h00);
		repeat (2) @(posedge clock_in);
		#1 chk("nak irq clear", 0, irq_out);
		$display("nak requests done");
		d = $urandom;
		wreg(16'he6d4, d);
		chk("start", 1, waveform_start_out);
		@(posedge clock_in);
		#1 chk("start end", 0, waveform_start_out);
		rchk(16'he6d4, 8'h00);
		for (int k = 0; k < 2; k++) begin
			d = $urandom;
			wreg(16'he648 + 16'(k), d);
			chk("pkt end", {1'b1, d[7], d[3:0]}, k ? force_out_cmd_out : force_in_cmd_out);
		end
		rchk(16'he649, 8'h00);
		$display("commands done");
		wreg(16'he6d3, 8'h01);
		@(posedge clock_in) waveform_busy_in <= 1;
		@(posedge clock_in) ep2_prog_flag_in <= 1;
		stop_win(1);
		ep2_prog_flag_in <= 0;
		wreg(16'he6d3, 8'h00);
		@(posedge clock_in) ep2_prog_flag_in <= 1;
		stop_win(0);
		$display("stop done");
		wrap_up;
	end
endmodule
`default_nettype wire
